// file: design/gpio_block.sv
// five-pin output drivers, alternate inputs and register slave
// assumes pins resolved outside from out/oe; inputs synchronous
module gpio_block
   import gpio_pkg::*;
#(
   parameter longint FAULT_CNT = FAULT_CYCLES,  // supply-low qualify time
   parameter longint DEB_TICK  = DEB_TICK_CYC,  // debounce tick period
   parameter longint CLK_HALF  = SLOW_HALF      // slow clock half period
) (
   input  wire logic        mclk_in,                  // 125 MHz clock
   input  wire logic        rstn_in,                  // async reset, low
   input  wire logic        hsel_in,                  // ahb select
   input  wire logic [31:0] haddr_in,                 // ahb address
   input  wire logic [1:0]  htrans_in,                // ahb transfer type
   input  wire logic        hwrite_in,                // ahb write
   input  wire logic [2:0]  hsize_in,                 // ahb size
   input  wire logic [31:0] hwdata_in,                // ahb write data
   input  wire logic        hready_in,                // ahb bus ready
   output logic [31:0]      hrdata_out,               // ahb read data
   output logic             hreadyout_out,            // ahb slave ready
   output logic             hresp_out,                // ahb response
   input  wire logic [4:0]  pin_in,                   // pad input levels
   output logic [4:0]       pin_out,                  // pad drive level
   output logic [4:0]       pin_oe_out,               // pad drive enable
   output logic [4:0]       pull_resistor_enable_out, // pad pull-up on
   output logic [1:0]       analog_sel_out,           // pins 0/1 analogue
   input  wire logic [4:0]  seq_pin_in,               // sequencer levels
   input  wire logic        seq_clk_en_in,            // sequencer clock enable
   input  wire logic [1:0]  power_state_in,           // power mode
   input  wire logic        supply_low_in,            // supply below threshold
   output logic             system_enable_out,        // system enable bit
   output logic             power_enable_out,         // power enable bit
   output logic             input_interrupt_event_out,// input event pulse
   output logic             wakeup_out,               // wakeup pulse
   output logic             low_power_state_req_out,        // low_power_state start pulse
   output logic             watchdog_clear_out,       // counter clear pulse
   output logic             watchdog_hold_mode_out,   // counter hold level
   output logic             supply_fault_flag_n_out,  // fault flag, low
   output logic             slow_clock_output_out     // gated slow clock
);
   // ==========================================================
   // register bus slave
   logic [31:0] func_q;
   logic [31:0] pinctl_q;
   logic [31:0] outsel_q;
   logic [31:0] ctrl_q;
   logic [7:0]  addr_q;
   logic        wr_q;
   logic        rd_q;
   logic [31:0] status_d;
   logic [31:0] rdata_d;
   logic        accept;

   assign accept = hsel_in & htrans_in[1] & hready_in;

   // latch the address phase; reads insert one wait state
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         addr_q        <= 8'h00;
         wr_q          <= 1'b0;
         rd_q          <= 1'b0;
         hreadyout_out <= 1'b1;
         hresp_out     <= 1'b0;
      end else begin
         wr_q <= accept & hwrite_in;
         rd_q <= accept & ~hwrite_in;
         if (accept) begin
            addr_q <= haddr_in[7:0];
         end
         if (accept & ~hwrite_in) begin
            hreadyout_out <= 1'b0;
         end else if (rd_q) begin
            hreadyout_out <= 1'b1;
         end
      end
   end

   // read mux, unmapped offsets read zero
   always_comb begin
      case (addr_q)
         REG_FUNC:   rdata_d = func_q;
         REG_PINCTL: rdata_d = pinctl_q;
         REG_OUTSEL: rdata_d = outsel_q;
         REG_CTRL:   rdata_d = ctrl_q;
         REG_STATUS: rdata_d = status_d;
         default:    rdata_d = 32'h0000_0000;
      endcase
   end

   // read data registered so the bus sees a flop
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         hrdata_out <= 32'h0000_0000;
      end else if (rd_q) begin
         hrdata_out <= rdata_d;
      end
   end

   // configuration writes land in the data phase
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         func_q   <= FUNC_RST;
         pinctl_q <= PINCTL_RST;
         outsel_q <= OUTSEL_RST;
         ctrl_q   <= CTRL_RST;
      end else if (wr_q) begin
         case (addr_q)
            REG_FUNC:   func_q   <= {22'h000000, hwdata_in[9:0]};
            REG_PINCTL: pinctl_q <= hwdata_in & 32'h1F1F_1F1F;
            REG_OUTSEL: outsel_q <= hwdata_in & 32'h03FF_7FFF;
            REG_CTRL:   ctrl_q   <= hwdata_in & 32'h0000_FF1F;
            default:    ;
         endcase
      end
   end

   // ==========================================================
   // time bases
   logic [31:0] tick_cnt_q;
   logic        deb_tick_q;
   logic [31:0] half_cnt_q;
   logic        slow_clk_q;

   // debounce tick divider
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tick_cnt_q <= 32'h0000_0000;
         deb_tick_q <= 1'b0;
      end else if (tick_cnt_q >= 32'(DEB_TICK - 1)) begin
         tick_cnt_q <= 32'h0000_0000;
         deb_tick_q <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
         deb_tick_q <= 1'b0;
      end
   end

   // slow clock from a free-running divider; not glitch-free on reselect
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         half_cnt_q <= 32'h0000_0000;
         slow_clk_q <= 1'b0;
      end else if (half_cnt_q >= 32'(CLK_HALF - 1)) begin
         half_cnt_q <= 32'h0000_0000;
         slow_clk_q <= ~slow_clk_q;
      end else begin
         half_cnt_q <= half_cnt_q + 32'h0000_0001;
      end
   end

   // ==========================================================
   // slow clock buffer and supply fault qualifier
   logic        buf_en;
   logic        in_pd;
   logic        gpio_on;
   logic [31:0] fault_cnt_q;

   assign in_pd   = (power_state_in == PS_PD);
   assign gpio_on = in_pd | (power_state_in == PS_ACTIVE);
   assign buf_en  = (seq_clk_en_in | ctrl_q[C_CLKEN]) & ~(ctrl_q[C_PAUSE] & in_pd);

   // buffered clock, can be toggled at run time
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         slow_clock_output_out <= 1'b0;
      end else begin
         slow_clock_output_out <= slow_clk_q & buf_en;
      end
   end

   // flag only once supply has stayed low longer than the qualify time
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         fault_cnt_q             <= 32'h0000_0000;
         supply_fault_flag_n_out <= 1'b1;
      end else if (!supply_low_in) begin
         fault_cnt_q             <= 32'h0000_0000;
         supply_fault_flag_n_out <= 1'b1;
      end else if (fault_cnt_q < 32'(FAULT_CNT)) begin
         fault_cnt_q <= fault_cnt_q + 32'h0000_0001;
      end else begin
         supply_fault_flag_n_out <= 1'b0;
      end
   end

   // ==========================================================
   // per-pin filtering and output drive
   logic [4:0] deb;
   logic [4:0] act;
   logic [4:0] act_q;
   logic [4:0] rise;
   logic [4:0] fall;
   logic [4:0] ana;

   assign ana = {3'b000, ctrl_q[C_TREF], ctrl_q[C_TERM] | ctrl_q[C_TREF]};

   // registered analogue hand-over
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         analog_sel_out <= 2'h0;
      end else begin
         analog_sel_out <= ana[1:0];
      end
   end

   generate
      for (genvar i = 0; i < 5; i++) begin : g_pin
         logic [1:0] fn;
         logic [2:0] src;
         logic [1:0] fsel;
         logic       lvl;
         logic       val;
         logic       fwd_ok;

         assign fn     = func_q[2*i +: 2];
         assign src    = outsel_q[3*i +: 3];
         assign fsel   = outsel_q[F_FWD + 2*i +: 2];
         assign lvl    = pinctl_q[F_LEVEL + i];
         assign fwd_ok = (i != 2) && (i != 4);

         debounce_filter #(.LW(8)) u_deb (
            .mclk_in (mclk_in),
            .rstn_in (rstn_in),
            .tick_in (deb_tick_q),
            .en_in   (pinctl_q[F_DEBEN + i]),
            .len_in  (ctrl_q[C_DEBLN +: 8]),
            .d_in    (pin_in[i]),
            .q_out   (deb[i])
         );

         // polarity bit 1 means active high
         assign act[i] = ~(deb[i] ^ pinctl_q[F_POL + i]);

         // output source select
         always_comb begin
            case (src)
               SRC_LEVEL: val = lvl;
               SRC_FWD:   val = fwd_ok ? deb[fsel] : lvl;
               SRC_SEQ:   val = seq_pin_in[i];
               SRC_CLK:   val = slow_clock_output_out;
               SRC_FAULT: val = supply_fault_flag_n_out ~^ lvl;
               default:   val = lvl;
            endcase
         end

         // driver type from function; disabled modes float open-drain
         always_ff @(posedge mclk_in or negedge rstn_in) begin
            if (!rstn_in) begin
               pin_out[i]                  <= 1'b0;
               pin_oe_out[i]               <= 1'b0;
               pull_resistor_enable_out[i] <= 1'b0;
            end else if (ana[i]) begin
               pin_out[i]                  <= 1'b0;
               pin_oe_out[i]               <= 1'b0;
               pull_resistor_enable_out[i] <= 1'b0;
            end else begin
               pull_resistor_enable_out[i] <= (fn == FN_OD) & pinctl_q[F_PULL + i];
               case (fn)
                  FN_PP: begin
                     pin_out[i]    <= val;
                     pin_oe_out[i] <= gpio_on;
                  end
                  FN_OD: begin
                     pin_out[i]    <= 1'b0;
                     pin_oe_out[i] <= gpio_on & ~val;
                  end
                  default: begin
                     pin_out[i]    <= 1'b0;
                     pin_oe_out[i] <= 1'b0;
                  end
               endcase
            end
         end
      end
   endgenerate

   // previous active levels for edge detection
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         act_q <= 5'h00;
      end else begin
         act_q <= act;
      end
   end

   // edges only while pins are live and not analogue
   assign rise = act & ~act_q & {5{gpio_on}} & ~ana;
   assign fall = ~act & act_q & {5{gpio_on}} & ~ana;

   // ==========================================================
   // alternate input functions, no general event logic
   logic alt0;
   logic alt2;
   logic alt4;

   assign alt0 = (func_q[1:0] == FN_ALT) & ~ana[0];
   assign alt2 = (func_q[5:4] == FN_ALT);
   assign alt4 = (func_q[9:8] == FN_ALT);

   // system and power enable bits follow their pins' edges
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         system_enable_out <= 1'b0;
         power_enable_out  <= 1'b0;
      end else begin
         if (alt4 & rise[4]) begin
            system_enable_out <= 1'b1;
         end else if (alt4 & fall[4]) begin
            system_enable_out <= 1'b0;
         end
         if (alt2 & rise[2]) begin
            power_enable_out <= 1'b1;
         end else if (alt2 & fall[2]) begin
            power_enable_out <= 1'b0;
         end
      end
   end

   // one-cycle pulses toward sequencer, interrupt logic and watchdog, plus the watchdog hold level
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         input_interrupt_event_out <= 1'b0;
         wakeup_out                <= 1'b0;
         low_power_state_req_out         <= 1'b0;
         watchdog_clear_out        <= 1'b0;
         watchdog_hold_mode_out    <= 1'b0;
      end else begin
         input_interrupt_event_out <= alt4 & rise[4];
         wakeup_out                <= (alt4 & rise[4]) |
                                      (alt2 & rise[2] & ctrl_q[C_WAKE2]);
         low_power_state_req_out         <= alt4 & fall[4];
         watchdog_clear_out        <= alt0 & rise[0];
         watchdog_hold_mode_out    <= alt0 & gpio_on & act[0];
      end
   end

   // status word
   assign status_d = {19'h00000, deb, 3'h0, buf_en, watchdog_hold_mode_out,
                      supply_fault_flag_n_out, power_enable_out, system_enable_out};
endmodule // gpio_block

// file: design/gpio_pkg.sv
// constants for the five-pin output and alternate-input block
// assumes a single 125 MHz clock and an AHB-Lite register bus
package gpio_pkg;
   // ==========================================================
   // register map
   localparam logic [7:0]  REG_FUNC   = 8'h00;
   localparam logic [7:0]  REG_PINCTL = 8'h04;
   localparam logic [7:0]  REG_OUTSEL = 8'h08;
   localparam logic [7:0]  REG_CTRL   = 8'h0C;
   localparam logic [7:0]  REG_STATUS = 8'h10;
   localparam logic [31:0] FUNC_RST   = 32'h0000_0155;
   localparam logic [31:0] PINCTL_RST = 32'h0000_0000;
   localparam logic [31:0] OUTSEL_RST = 32'h0000_0000;
   localparam logic [31:0] CTRL_RST   = 32'h0000_0A00;
   // ==========================================================
   // field positions
   localparam int F_LEVEL = 0;
   localparam int F_PULL  = 8;
   localparam int F_POL   = 16;
   localparam int F_DEBEN = 24;
   localparam int F_FWD   = 16;
   localparam int C_CLKEN = 0;
   localparam int C_PAUSE = 1;
   localparam int C_TERM  = 2;
   localparam int C_TREF  = 3;
   localparam int C_WAKE2 = 4;
   localparam int C_DEBLN = 8;
   // ==========================================================
   // encodings
   localparam logic [1:0] FN_ALT = 2'h0;
   localparam logic [1:0] FN_IN  = 2'h1;
   localparam logic [1:0] FN_OD  = 2'h2;
   localparam logic [1:0] FN_PP  = 2'h3;
   localparam logic [2:0] SRC_LEVEL = 3'h0;
   localparam logic [2:0] SRC_FWD   = 3'h1;
   localparam logic [2:0] SRC_SEQ   = 3'h2;
   localparam logic [2:0] SRC_CLK   = 3'h3;
   localparam logic [2:0] SRC_FAULT = 3'h4;
   localparam logic [1:0] PS_PD     = 2'h1;
   localparam logic [1:0] PS_ACTIVE = 2'h2;
   // ==========================================================
   // timing
   localparam longint CLK_HZ         = 125_000_000;
   localparam longint FAULT_MS       = 100;
   localparam longint FAULT_CYCLES   = FAULT_MS * CLK_HZ / 1000;
   localparam longint SLOW_HZ        = 32_768;
   localparam longint SLOW_HALF      = CLK_HZ / (2 * SLOW_HZ);
   localparam longint DEB_TICK_US    = 100;
   localparam longint DEB_TICK_CYC   = DEB_TICK_US * CLK_HZ / 1_000_000;
endpackage : gpio_pkg

// file: design/debounce_filter.sv
// one pin's input synchroniser and debounce filter
// assumes tick_in is a one-cycle enable from the caller's divider
module debounce_filter #(
   parameter int LW = 8
) (
   input  wire logic          mclk_in,  // clock
   input  wire logic          rstn_in,  // async reset, low
   input  wire logic          tick_in,  // debounce time base
   input  wire logic          en_in,    // debounce on
   input  wire logic [LW-1:0] len_in,   // stable ticks needed
   input  wire logic          d_in,     // raw pin level
   output logic               q_out     // filtered level
);
   logic          s1_q;
   logic          s2_q;
   logic [LW-1:0] cnt_q;

   // two-stage synchroniser, first stage feeds only the second
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
      end else begin
         s1_q <= d_in;
         s2_q <= s1_q;
      end
   end

   // with debounce on, accept a new level only once it has held for len ticks
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cnt_q <= '0;
         q_out <= 1'b0;
      end else if (!en_in) begin
         cnt_q <= '0;
         q_out <= s2_q;
      end else if (s2_q == q_out) begin
         cnt_q <= '0;
      end else if (tick_in) begin
         if (cnt_q + 1'b1 >= len_in) begin
            cnt_q <= '0;
            q_out <= s2_q;
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end
endmodule // debounce_filter

// file: test/gpio_board.sv
// board model: resolves the five pads
// assumes the bench drives drv_en_in/drv_val_in after rising edges
module gpio_board (
   input  wire logic       mclk_in,    // clock
   input  wire logic [4:0] pin_out_in, // block drive level
   input  wire logic [4:0] pin_oe_in,  // block drive enable
   input  wire logic [4:0] pull_in,    // pull-up enables
   input  wire logic [4:0] drv_en_in,  // board drives pad
   input  wire logic [4:0] drv_val_in, // board drive level
   output logic      [4:0] pad_out     // resolved pad level
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // undriven, unpulled pad flips each cycle
   logic [4:0] float_q = 5'h00;
   always_ff @(posedge mclk_in) begin
      float_q <= ~pad_out;
   end
   // block first, then board, then pull-up, else noise
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         if (pin_oe_in[i]) pad_out[i] = pin_out_in[i];
         else if (drv_en_in[i]) pad_out[i] = drv_val_in[i];
         else if (pull_in[i]) pad_out[i] = 1'b1;
         else pad_out[i] = float_q[i];
      end
   end
endmodule // gpio_board

// file: test/gpio_block_props.sv
// checker for the five-pin gpio block
// bound into gpio_block; sees only its ports
module gpio_block_props
   import gpio_pkg::*;
#(
   parameter longint FAULT_CNT = FAULT_CYCLES  // supply-low qualify time
) (
   input wire logic       mclk_in,                   // clock
   input wire logic       rstn_in,                   // async reset, low
   input wire logic       hreadyout_out,             // slave ready
   input wire logic       hresp_out,                 // response
   input wire logic [4:0] pin_oe_out,                // pad drive enable
   input wire logic [1:0] power_state_in,            // power mode
   input wire logic       supply_low_in,             // supply low
   input wire logic       system_enable_out,         // system enable
   input wire logic       power_enable_out,          // power enable
   input wire logic       input_interrupt_event_out, // event pulse
   input wire logic       wakeup_out,                // wakeup pulse
   input wire logic       low_power_state_req_out,         // low_power_state pulse
   input wire logic       watchdog_clear_out,        // counter clear
   input wire logic       watchdog_hold_mode_out,    // counter hold
   input wire logic       supply_fault_flag_n_out    // fault flag, low
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);
   // ==========================================================
   // consecutive supply-low cycles behind the fault flag
   logic [31:0] low_cnt_q;
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) low_cnt_q <= 32'h0000_0000;
      else if (supply_low_in) low_cnt_q <= low_cnt_q + 32'h0000_0001;
      else low_cnt_q <= 32'h0000_0000;
   end
   sequence s_off;
      !(power_state_in == PS_PD || power_state_in == PS_ACTIVE);
   endsequence
   sequence s_off2;
      s_off ##1 s_off;
   endsequence
   sequence s_sys_rise;
      $rose(system_enable_out);
   endsequence
   // ==========================================================
   a_resp_okay: assert property (hresp_out == 1'b0)
      else $error("response not okay");
   a_wait_short: assert property (!hreadyout_out |=> hreadyout_out)
      else $error("wait state too long");
   a_float_off: assert property (s_off |=> pin_oe_out == 5'h00)
      else $error("pad driven while off");
   a_off_frozen: assert property (s_off2 |=>
      $stable(system_enable_out) && $stable(power_enable_out))
      else $error("enable changed while off");
   a_rise_wakes: assert property (s_sys_rise |->
      wakeup_out && input_interrupt_event_out)
      else $error("rise without event or wakeup");
   a_irq_cause: assert property (input_interrupt_event_out |->
      $rose(system_enable_out))
      else $error("event without enable rise");
   a_pd_quiet: assert property (low_power_state_req_out |->
      !system_enable_out && !input_interrupt_event_out)
      else $error("low_power_state request wrong");
   a_kick_clears: assert property (watchdog_clear_out |-> watchdog_hold_mode_out)
      else $error("clear without hold");
   a_fault_held: assert property (!supply_fault_flag_n_out |->
      low_cnt_q >= 32'(FAULT_CNT))
      else $error("fault flag early");
   a_fault_timely: assert property (low_cnt_q == 32'(FAULT_CNT) + 32'h3 |->
      !supply_fault_flag_n_out)
      else $error("fault flag late");
   a_fault_release: assert property (!supply_low_in |=> supply_fault_flag_n_out)
      else $error("fault flag kept");
endmodule // gpio_block_props

bind gpio_block gpio_block_props #(.FAULT_CNT(FAULT_CNT)) i_gpio_block_props (
   .mclk_in, .rstn_in, .hreadyout_out, .hresp_out, .pin_oe_out, .power_state_in,
   .supply_low_in, .system_enable_out, .power_enable_out, .input_interrupt_event_out,
   .wakeup_out, .low_power_state_req_out, .watchdog_clear_out, .watchdog_hold_mode_out,
   .supply_fault_flag_n_out);

// file: test/gpio_block_tb_top.sv
// self-checking bench for gpio_block with a board model
// assumes short fault, debounce and slow clock parameters
module gpio_block_tb_top;
   import gpio_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
   localparam longint FCNT = 50;
   logic mclk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hresp;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
   logic [1:0] htrans = 2'h0, ps = 2'h0, asel;
   logic [4:0] pin_i, pin_o, pin_oe, pull, seq_pin = 5'h00, drv_en = 5'h00, drv_val = 5'h00;
   logic seq_clk_en = 1'b0, supply_low = 1'b0, system_enable_input, power_enable_input, irq, wake, pd_req;
   logic wd_clr, wd_hold, fault_n, sclk, p2_last;
   int n_fail = 0, checks_done = 0, seed, irq_c, wake_c, pd_c, clr_c, edge_c = 0;
   // ==========================================================
   always #4 mclk = ~mclk;
   gpio_block #(.FAULT_CNT(FCNT), .DEB_TICK(4), .CLK_HALF(4)) i_gpio_block (
      .mclk_in(mclk), .rstn_in(rstn), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
      .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
      .hresp_out(hresp), .pin_in(pin_i), .pin_out(pin_o), .pin_oe_out(pin_oe),
      .pull_resistor_enable_out(pull), .analog_sel_out(asel), .seq_pin_in(seq_pin),
      .seq_clk_en_in(seq_clk_en), .power_state_in(ps), .supply_low_in(supply_low),
      .system_enable_out(system_enable_input), .power_enable_out(power_enable_input),
      .input_interrupt_event_out(irq), .wakeup_out(wake), .low_power_state_req_out(pd_req),
      .watchdog_clear_out(wd_clr), .watchdog_hold_mode_out(wd_hold),
      .supply_fault_flag_n_out(fault_n), .slow_clock_output_out(sclk));
   gpio_board i_gpio_board (.mclk_in(mclk), .pin_out_in(pin_o), .pin_oe_in(pin_oe),
      .pull_in(pull), .drv_en_in(drv_en), .drv_val_in(drv_val), .pad_out(pin_i));
   // pulse and pad-edge tallies
   always @(posedge mclk) begin
      irq_c += (irq === 1'b1);
      wake_c += (wake === 1'b1);
      pd_c += (pd_req === 1'b1);
      clr_c += (wd_clr === 1'b1);
      edge_c += (pin_o[2] !== p2_last);
      p2_last = pin_o[2];
   end
   // ==========================================================
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // address phase held until ready, then data phase
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h000000, a};
      do begin @(posedge mclk); n++; end while (hready !== 1'b1 && n < 40);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      do begin @(posedge mclk); n++; end while (hready !== 1'b1 && n < 40);
      q = hrdata;
      if (n >= 40) n_fail++;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      ahb(1'b1, a, d, q);
      tick(3);
   endtask
   // slow clock pad toggles every 4 cycles when on
   task automatic clk_run(input logic run);
      int e0, d;
      tick(4); e0 = edge_c; tick(64); d = edge_c - e0;
      `CHK("slow clock", 1'b1, run ? (d >= 15 && d <= 17) : (d == 0))
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // watchdog, far beyond the run
   initial begin
      #400000;
      n_fail++;
      summarize();
   end
   // ==========================================================
   initial begin
      seed = 78361;
      tick(20);
      rstn <= 1'b1;
      @(posedge mclk);
      ahb(1'b0, REG_FUNC, 32'h0, v); `CHK("func", FUNC_RST, v)
      ahb(1'b0, REG_PINCTL, 32'h0, v); `CHK("pinctl", PINCTL_RST, v)
      ahb(1'b0, REG_OUTSEL, 32'h0, v); `CHK("outsel", OUTSEL_RST, v)
      ahb(1'b0, REG_CTRL, 32'h0, v); `CHK("ctrl", CTRL_RST, v)
      ahb(1'b0, 8'h14, 32'h0, v); `CHK("unmapped", 32'h0, v)
      ps <= PS_ACTIVE;
      // static levels: push-pull, then open-drain
      for (int k = 0; k < 4; k++) begin
         v = $random(seed) & 32'h0000_1F1F;
         wr(REG_PINCTL, v);
         wr(REG_FUNC, 32'h0000_03FF);
         `CHK("pp oe", 5'h1F, pin_oe)
         `CHK("pp level", v[4:0], pin_o)
         `CHK("pp pull", 5'h00, pull)
         wr(REG_FUNC, 32'h0000_02AA);
         `CHK("od oe", ~v[4:0], pin_oe)
         `CHK("od pull", v[12:8], pull)
      end
      ps <= 2'h0; tick(3);
      `CHK("off oe", 5'h00, pin_oe)
      ps <= PS_ACTIVE; tick(3);
      `CHK("kept oe", ~v[4:0], pin_oe)
      // pin0 sequencer, pin3 forwards pin1, pin2 slow clock, pin4 fault
      wr(REG_FUNC, 32'h0000_03F7);
      wr(REG_PINCTL, 32'h0000_0010);
      wr(REG_OUTSEL, 32'h0040_42C2);
      drv_en <= 5'h02;
      for (int k = 0; k < 4; k++) begin
         v = $random(seed);
         seq_pin <= v[4:0]; drv_val <= {3'h0, v[5], 1'b0}; tick(10);
         `CHK("sequencer", v[0], pin_o[0])
         `CHK("forward", v[5], pin_o[3])
      end
      supply_low <= 1'b1; tick(FCNT - 5);
      `CHK("fault early", 1'b1, pin_o[4])
      tick(10);
      `CHK("fault", 1'b0, pin_o[4])
      wr(REG_PINCTL, 32'h0000_0000);
      `CHK("fault inverted", 1'b1, pin_o[4])
      supply_low <= 1'b0; tick(3);
      `CHK("fault clear", 1'b0, pin_o[4])
      clk_run(1'b0);
      wr(REG_CTRL, 32'h0000_0A01); clk_run(1'b1);
      wr(REG_CTRL, 32'h0000_0A03); ps <= PS_PD; clk_run(1'b0);
      ps <= PS_ACTIVE; clk_run(1'b1);
      wr(REG_CTRL, 32'h0000_0A00); seq_clk_en <= 1'b1; clk_run(1'b1);
      for (int k = 0; k < 2; k++) begin
         wr(REG_CTRL, k ? 32'h0000_0A04 : 32'h0000_0A08);
         `CHK("analogue pin0", 1'b0, pin_oe[0])
         `CHK("digital pin3", 1'b1, pin_oe[3])
         `CHK("analogue sel", k ? 2'h1 : 2'h3, asel)
      end
      // alternates: pin4 active low, pins 0, 2 active high
      wr(REG_CTRL, 32'h0000_0A00);
      drv_en <= 5'h1F; drv_val <= 5'h10;
      wr(REG_FUNC, 32'h0000_0044);
      wr(REG_PINCTL, 32'h0005_0000);
      tick(10); irq_c = 0; wake_c = 0; pd_c = 0; clr_c = 0;
      drv_val[4] <= 1'b0; tick(10);
      `CHK("system_enable_input", 1'b1, system_enable_input)
      `CHK("irq and wake", 2, irq_c + wake_c)
      drv_val[4] <= 1'b1; tick(10);
      `CHK("system_enable_input off", 1'b0, system_enable_input)
      `CHK("pd no irq", 11, pd_c * 10 + irq_c)
      drv_val[2] <= 1'b1; tick(10);
      `CHK("power_enable_input", 1'b1, power_enable_input)
      `CHK("no wake", 1, wake_c)
      drv_val[2] <= 1'b0; tick(10);
      `CHK("power_enable_input off", 1'b0, power_enable_input)
      wr(REG_CTRL, 32'h0000_0A10);
      drv_val[2] <= 1'b1; tick(10);
      `CHK("wake", 2, wake_c)
      drv_val[0] <= 1'b1; tick(30);
      `CHK("kick clear", 1, clr_c)
      `CHK("hold", 1'b1, wd_hold)
      drv_val[0] <= 1'b0; tick(10);
      `CHK("hold off", 1'b0, wd_hold)
      `CHK("alt no irq", 1, irq_c)
      // pin4 debounce: glitch dropped, held level taken
      wr(REG_PINCTL, 32'h1005_0000);
      tick(60);
      drv_val[4] <= 1'b0; tick(2 + ($random(seed) & 7)); drv_val[4] <= 1'b1; tick(60);
      `CHK("glitch", 1'b0, system_enable_input)
      drv_val[4] <= 1'b0; tick(80);
      `CHK("debounced", 1'b1, system_enable_input)
      summarize();
   end
endmodule // gpio_block_tb_top
